// [logic/ocp_delay_timer.sv]
// delay timer that counts while run is high and restarts whenever run drops
`timescale 1ns/1ns
module ocp_delay_timer #(
    parameter int LIMIT = ocp_pkg::OC_DELAY_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic run,
    output logic      expired
);

    ocp_pkg::ocp_timer_t cur;
    ocp_pkg::ocp_timer_t next_cur;

    // =====================================================================
    // counter
    // =====================================================================
    // saturates at LIMIT - 1 so a stalled consumer never sees a wrap
    always_comb begin
        next_cur = cur;
        if (!run) begin
            next_cur.count = '0;
        end else if (cur.count != ocp_pkg::TIMER_W'(LIMIT - 1)) begin
            next_cur.count = cur.count + ocp_pkg::TIMER_W'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // high in the cycle that completes LIMIT cycles of running
    assign expired = run && (cur.count == ocp_pkg::TIMER_W'(LIMIT - 1));

endmodule : ocp_delay_timer

// [logic/ocp_pkg.sv]
// shared constants, register map and state types of the over-current protection controller
package ocp_pkg;

    // =====================================================================
    // timing: both delays come from one timing capacitor
    // =====================================================================
    localparam int OC_DELAY_PER_UF_MS = 10000;               // delay per microfarad of timing capacitance
    localparam int OC_CAP_PF          = 1000;                // 0.001 uF timing capacitor
    localparam int OC_DELAY_US        = (OC_DELAY_PER_UF_MS * OC_CAP_PF) / 1000; // 10 ms expressed in us
    localparam int CLK_PERIOD_NS      = 4;                   // 250 MHz system clock
    localparam int OC_DELAY_CYCLES    = (OC_DELAY_US * 1000) / CLK_PERIOD_NS;
    localparam int TIMER_W            = 32;
    // load samples younger than the synchroniser depth were taken before the probe current flowed
    localparam logic [1:0] PROBE_SETTLE = 2'h2;

    // =====================================================================
    // register bus
    // =====================================================================
    localparam int          ADDR_W         = 8;
    localparam logic [7:0]  OFS_CONFIG     = 8'h00;          // threshold select
    localparam logic [7:0]  OFS_CTRL       = 8'h04;          // fet control bits
    localparam logic [7:0]  OFS_STATUS     = 8'h08;          // live state, read only
    localparam logic [7:0]  OFS_IRQ_STATUS = 8'h0C;          // sticky events, read only
    localparam logic [7:0]  OFS_IRQ_CLEAR  = 8'h10;          // write one to clear, write only
    localparam logic [7:0]  OFS_IRQ_ENABLE = 8'h14;          // interrupt mask
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // field positions
    localparam int CFG_THR_LO   = 0;                         // oc_threshold_sel_lo
    localparam int CFG_THR_HI   = 1;                         // oc_threshold_sel_hi
    localparam int CTRL_DIS     = 0;                         // discharge_fet_ctrl_bit
    localparam int CTRL_CHG     = 1;                         // charge_fet_ctrl_bit
    localparam int STAT_STATE   = 0;                         // four bits of one-hot state
    localparam int STAT_DIS_OFF = 4;
    localparam int STAT_CHG_ON  = 5;
    localparam int STAT_TEST    = 6;
    localparam int STAT_REG_EN  = 7;
    localparam int IRQ_ENTRY    = 0;                         // protection entered
    localparam int IRQ_RELEASE  = 1;                         // protection released
    localparam int IRQ_CANCEL   = 2;                         // detection cancelled
    localparam int IRQ_W        = 3;

    // reset values
    localparam logic [1:0]       RST_THR_SEL = 2'h0;
    localparam logic             RST_DIS_CTL = 1'b1;         // discharge fet on after reset
    localparam logic             RST_CHG_CTL = 1'b1;         // charge fet on after reset
    localparam logic [IRQ_W-1:0] RST_IRQ_EN  = 3'h0;

    // =====================================================================
    // state types
    // =====================================================================
    typedef enum logic [3:0] {
        ST_NORMAL   = 4'h1,
        ST_DETECT   = 4'h2,
        ST_LOAD_MON = 4'h4,
        ST_RELEASE  = 4'h8
    } ocp_state_t;

    typedef struct packed {
        logic [TIMER_W-1:0] count;
    } ocp_timer_t;

    typedef struct packed {
        ocp_state_t         state;
        logic               over_s1;
        logic               over_s2;
        logic               load_s1;
        logic               load_s2;
        logic [1:0]         thr_sel;
        logic               dis_ctrl;
        logic               chg_ctrl;
        logic               dis_at_entry;
        logic               dis_off;
        logic               chg_on;
        logic               test_en;
        logic [1:0]         probe_age;
        logic [IRQ_W-1:0]   irq_status;
        logic [IRQ_W-1:0]   irq_enable;
        logic               aw_held;
        logic [ADDR_W-1:0]  aw_addr;
        logic               w_held;
        logic [31:0]        wdata;
        logic [3:0]         wstrb;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               rvalid;
        logic [31:0]        rdata;
        logic [1:0]         rresp;
    } ocp_regs_t;

endpackage : ocp_pkg

// [logic/ocp_protect_fsm.sv]
// over-current protection state machine with its axi4-lite register file
`timescale 1ns/1ns
module ocp_protect_fsm #(
    parameter int DELAY_CYCLES = ocp_pkg::OC_DELAY_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        sense_over_threshold,
    input  wire logic        load_above_release,
    output logic             discharge_fet_drive,
    output logic             charge_fet_on,
    output logic             load_test_current_en,
    output logic             regulated_supply_out_en,
    output logic [1:0]       oc_threshold_sel,
    output logic             irq,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    ocp_pkg::ocp_regs_t cur;
    ocp_pkg::ocp_regs_t next_cur;
    logic               timer_run;
    logic               timer_expired;
    logic               in_prot;
    logic               do_write;
    logic               release_evt;
    logic [ocp_pkg::IRQ_W-1:0] irq_set;
    logic [ocp_pkg::IRQ_W-1:0] irq_clr;

    // =====================================================================
    // helpers
    // =====================================================================
    // word-aligned decode, shared by the read and write paths
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr[7:2] == ofs[7:2]);
    endfunction : hit

    function automatic logic mapped(input logic [7:0] addr);
        mapped = hit(addr, ocp_pkg::OFS_CONFIG) || hit(addr, ocp_pkg::OFS_CTRL) ||
                 hit(addr, ocp_pkg::OFS_STATUS) || hit(addr, ocp_pkg::OFS_IRQ_STATUS) ||
                 hit(addr, ocp_pkg::OFS_IRQ_CLEAR) || hit(addr, ocp_pkg::OFS_IRQ_ENABLE);
    endfunction : mapped

    // =====================================================================
    // shared delay timer
    // =====================================================================
    // one timer serves both delays, they can never run at the same time
    assign timer_run = (cur.state == ocp_pkg::ST_DETECT) || (cur.state == ocp_pkg::ST_RELEASE);

    ocp_delay_timer #(
        .LIMIT (DELAY_CYCLES)
    ) u_timer (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .run     (timer_run),
        .expired (timer_expired)
    );

    assign in_prot  = (cur.state == ocp_pkg::ST_LOAD_MON) || (cur.state == ocp_pkg::ST_RELEASE);
    assign do_write = cur.aw_held && cur.w_held && !cur.bvalid;
    assign release_evt = (cur.state == ocp_pkg::ST_RELEASE) && cur.load_s2 && timer_expired && !cur.over_s2;

    // =====================================================================
    // next state
    // =====================================================================
    always_comb begin
        next_cur = cur;
        irq_set  = '0;
        irq_clr  = '0;

        // comparator results arrive from the analog side, two flops before use
        next_cur.over_s1 = sense_over_threshold;
        next_cur.over_s2 = cur.over_s1;
        next_cur.load_s1 = load_above_release;
        next_cur.load_s2 = cur.load_s1;

        // register writes land first so the state machine can override the fet bits
        if (do_write && cur.wstrb[0]) begin
            if (hit(cur.aw_addr, ocp_pkg::OFS_CONFIG)) begin
                next_cur.thr_sel = cur.wdata[ocp_pkg::CFG_THR_HI:ocp_pkg::CFG_THR_LO];
            end
            if (hit(cur.aw_addr, ocp_pkg::OFS_CTRL)) begin
                next_cur.dis_ctrl = cur.wdata[ocp_pkg::CTRL_DIS];
                next_cur.chg_ctrl = cur.wdata[ocp_pkg::CTRL_CHG];
            end
            if (hit(cur.aw_addr, ocp_pkg::OFS_IRQ_ENABLE)) begin
                next_cur.irq_enable = cur.wdata[ocp_pkg::IRQ_W-1:0];
            end
            if (hit(cur.aw_addr, ocp_pkg::OFS_IRQ_CLEAR)) begin
                irq_clr = cur.wdata[ocp_pkg::IRQ_W-1:0];
            end
        end

        // outside protection the pins follow the control bits
        if (!in_prot) begin
            next_cur.dis_off = !next_cur.dis_ctrl;
            next_cur.chg_on  = next_cur.chg_ctrl;
        end

        case (cur.state)
            ocp_pkg::ST_NORMAL: begin
                if (cur.over_s2) begin
                    next_cur.state = ocp_pkg::ST_DETECT;
                end
            end
            ocp_pkg::ST_DETECT: begin
                if (!cur.over_s2) begin
                    next_cur.state = ocp_pkg::ST_NORMAL;
                    irq_set[ocp_pkg::IRQ_CANCEL] = 1'b1;
                end else if (timer_expired) begin
                    next_cur.state        = ocp_pkg::ST_LOAD_MON;
                    next_cur.dis_off      = 1'b1;
                    next_cur.chg_on       = cur.chg_on;
                    next_cur.test_en      = 1'b1;
                    next_cur.probe_age    = 2'h0;
                    next_cur.dis_at_entry = next_cur.dis_ctrl;
                    irq_set[ocp_pkg::IRQ_ENTRY] = 1'b1;
                end
            end
            ocp_pkg::ST_LOAD_MON: begin
                next_cur.test_en = 1'b1;
                // ignore the load reading until it was sampled with the probe current on
                if (cur.probe_age != ocp_pkg::PROBE_SETTLE) begin
                    next_cur.probe_age = cur.probe_age + 2'h1;
                end else if (cur.load_s2) begin
                    next_cur.state   = ocp_pkg::ST_RELEASE;
                    next_cur.test_en = 1'b0;
                end
            end
            ocp_pkg::ST_RELEASE: begin
                if (!cur.load_s2) begin
                    // the load dropped again, go back to probing with a fresh delay
                    next_cur.state     = ocp_pkg::ST_LOAD_MON;
                    next_cur.test_en   = 1'b1;
                    next_cur.probe_age = 2'h0;
                end else if (timer_expired) begin
                    if (!cur.over_s2) begin
                        next_cur.state   = ocp_pkg::ST_NORMAL;
                        next_cur.chg_on  = cur.chg_on;
                        if (next_cur.dis_ctrl == cur.dis_at_entry) begin
                            next_cur.dis_ctrl = 1'b1;
                            next_cur.dis_off  = 1'b0;
                        end else begin
                            next_cur.dis_off  = !next_cur.dis_ctrl;
                        end
                        irq_set[ocp_pkg::IRQ_RELEASE] = 1'b1;
                    end else begin
                        next_cur.state     = ocp_pkg::ST_LOAD_MON;
                        next_cur.test_en   = 1'b1;
                        next_cur.probe_age = 2'h0;
                    end
                end
            end
            default: begin
                next_cur.state   = ocp_pkg::ST_NORMAL;
                next_cur.test_en = 1'b0;
            end
        endcase

        // set wins over a clear in the same cycle
        next_cur.irq_status = (cur.irq_status & ~irq_clr) | irq_set;

        // write channel: address and data are taken independently
        if (s_axi_awvalid && s_axi_awready) begin
            next_cur.aw_held = 1'b1;
            next_cur.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_cur.w_held = 1'b1;
            next_cur.wdata  = s_axi_wdata;
            next_cur.wstrb  = s_axi_wstrb;
        end
        if (do_write) begin
            next_cur.aw_held = 1'b0;
            next_cur.w_held  = 1'b0;
            next_cur.bvalid  = 1'b1;
            next_cur.bresp   = mapped(cur.aw_addr) && !hit(cur.aw_addr, ocp_pkg::OFS_STATUS) &&
                               !hit(cur.aw_addr, ocp_pkg::OFS_IRQ_STATUS) ? ocp_pkg::RESP_OKAY : ocp_pkg::RESP_SLVERR;
        end else if (cur.bvalid && s_axi_bready) begin
            next_cur.bvalid = 1'b0;
        end

        // read channel: data registered on the same edge that takes the address, valid in the following cycle
        if (s_axi_arvalid && s_axi_arready) begin
            next_cur.rvalid = 1'b1;
            next_cur.rresp  = mapped(s_axi_araddr) ? ocp_pkg::RESP_OKAY : ocp_pkg::RESP_SLVERR;
            next_cur.rdata  = 32'h0000_0000;
            if (hit(s_axi_araddr, ocp_pkg::OFS_CONFIG)) begin
                next_cur.rdata[1:0] = cur.thr_sel;
            end
            if (hit(s_axi_araddr, ocp_pkg::OFS_CTRL)) begin
                next_cur.rdata[ocp_pkg::CTRL_DIS] = cur.dis_ctrl;
                next_cur.rdata[ocp_pkg::CTRL_CHG] = cur.chg_ctrl;
            end
            if (hit(s_axi_araddr, ocp_pkg::OFS_STATUS)) begin
                next_cur.rdata[ocp_pkg::STAT_STATE+3:ocp_pkg::STAT_STATE] = cur.state;
                next_cur.rdata[ocp_pkg::STAT_DIS_OFF] = cur.dis_off;
                next_cur.rdata[ocp_pkg::STAT_CHG_ON]  = cur.chg_on;
                next_cur.rdata[ocp_pkg::STAT_TEST]    = cur.test_en;
                next_cur.rdata[ocp_pkg::STAT_REG_EN]  = 1'b1;
            end
            if (hit(s_axi_araddr, ocp_pkg::OFS_IRQ_STATUS)) begin
                next_cur.rdata[ocp_pkg::IRQ_W-1:0] = cur.irq_status;
            end
            if (hit(s_axi_araddr, ocp_pkg::OFS_IRQ_ENABLE)) begin
                next_cur.rdata[ocp_pkg::IRQ_W-1:0] = cur.irq_enable;
            end
        end else if (cur.rvalid && s_axi_rready) begin
            next_cur.rvalid = 1'b0;
        end
    end

    // =====================================================================
    // state register
    // =====================================================================
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur            <= '0;
            cur.state      <= ocp_pkg::ST_NORMAL;
            cur.thr_sel    <= ocp_pkg::RST_THR_SEL;
            cur.dis_ctrl   <= ocp_pkg::RST_DIS_CTL;
            cur.chg_ctrl   <= ocp_pkg::RST_CHG_CTL;
            cur.dis_off    <= !ocp_pkg::RST_DIS_CTL;
            cur.chg_on     <= ocp_pkg::RST_CHG_CTL;
            cur.irq_enable <= ocp_pkg::RST_IRQ_EN;
        end else begin
            cur <= next_cur;
        end
    end

    // =====================================================================
    // outputs
    // =====================================================================
    assign discharge_fet_drive     = cur.dis_off;      // high is the off level
    assign charge_fet_on           = cur.chg_on;
    assign load_test_current_en    = cur.test_en;
    assign regulated_supply_out_en = 1'b1;
    assign oc_threshold_sel        = cur.thr_sel;
    assign irq                     = |(cur.irq_status & cur.irq_enable);
    assign s_axi_awready           = !cur.aw_held && !cur.bvalid;
    assign s_axi_wready            = !cur.w_held && !cur.bvalid;
    assign s_axi_bvalid            = cur.bvalid;
    assign s_axi_bresp             = cur.bresp;
    assign s_axi_arready           = !cur.rvalid;
    assign s_axi_rvalid            = cur.rvalid;
    assign s_axi_rdata             = cur.rdata;
    assign s_axi_rresp             = cur.rresp;

    // =====================================================================
    // assertions
    // =====================================================================
    property p_detect_start;
        @(posedge sys_clk) disable iff (!rst_n)
        (cur.state == ocp_pkg::ST_NORMAL && cur.over_s2) |=> (cur.state == ocp_pkg::ST_DETECT);
    endproperty
    a_detect_start: assert property (p_detect_start) else $error("over threshold did not start detection");

    property p_entry;
        @(posedge sys_clk) disable iff (!rst_n)
        (cur.state == ocp_pkg::ST_DETECT && cur.over_s2 && timer_expired) |=>
            (cur.state == ocp_pkg::ST_LOAD_MON && discharge_fet_drive && load_test_current_en);
    endproperty
    a_entry: assert property (p_entry) else $error("protection entry did not switch fet off and start probe");

    property p_off_in_prot;
        @(posedge sys_clk) disable iff (!rst_n)
        in_prot |-> discharge_fet_drive;
    endproperty
    a_off_in_prot: assert property (p_off_in_prot) else $error("discharge fet on during protection");

    property p_supply;
        @(posedge sys_clk) disable iff (!rst_n)
        in_prot |-> regulated_supply_out_en;
    endproperty
    a_supply: assert property (p_supply) else $error("regulated supply dropped in protection");

    property p_probe;
        @(posedge sys_clk) disable iff (!rst_n)
        (cur.state == ocp_pkg::ST_LOAD_MON) |-> load_test_current_en;
    endproperty
    a_probe: assert property (p_probe) else $error("no test current in load monitor");

    property p_release_wait;
        @(posedge sys_clk) disable iff (!rst_n)
        (cur.state == ocp_pkg::ST_LOAD_MON && cur.load_s2 && cur.probe_age == ocp_pkg::PROBE_SETTLE) |=>
            (cur.state == ocp_pkg::ST_RELEASE && !load_test_current_en);
    endproperty
    a_release_wait: assert property (p_release_wait) else $error("release delay not started");

    property p_restore;
        @(posedge sys_clk) disable iff (!rst_n)
        (release_evt && cur.dis_ctrl == cur.dis_at_entry && !(do_write && hit(cur.aw_addr, ocp_pkg::OFS_CTRL)))
            |=> (!discharge_fet_drive && cur.state == ocp_pkg::ST_NORMAL && !load_test_current_en);
    endproperty
    a_restore: assert property (p_restore) else $error("discharge fet not restored on release");

    property p_hold_pins;
        @(posedge sys_clk) disable iff (!rst_n)
        (in_prot ##1 in_prot) |-> ($stable(discharge_fet_drive) && $stable(charge_fet_on));
    endproperty
    a_hold_pins: assert property (p_hold_pins) else $error("fet pins moved during protection");

    property p_charge_kept;
        @(posedge sys_clk) disable iff (!rst_n)
        release_evt |=> (charge_fet_on == $past(charge_fet_on));
    endproperty
    a_charge_kept: assert property (p_charge_kept) else $error("charge fet changed at release");

    property p_cancel;
        @(posedge sys_clk) disable iff (!rst_n)
        (cur.state == ocp_pkg::ST_DETECT && !cur.over_s2) |=>
            (cur.state == ocp_pkg::ST_NORMAL && discharge_fet_drive == !cur.dis_ctrl);
    endproperty
    a_cancel: assert property (p_cancel) else $error("detection not cancelled");

endmodule : ocp_protect_fsm

// [verification/ocp_pack_model.sv]
// pack side model: sense resistor, discharge fet and load
`timescale 1ns/1ns
module ocp_pack_model (
    input  wire logic overload,
    input  wire logic discharge_fet_drive,
    input  wire logic load_test_current_en,
    output logic      sense_over_threshold,
    output logic      load_above_release
);
    // an open fet blocks pack current, so the sense difference collapses
    assign sense_over_threshold = overload & ~discharge_fet_drive;
    // a heavy load reads as low resistance only while the probe current flows
    assign load_above_release = ~(overload & load_test_current_en);
endmodule : ocp_pack_model

// [verification/ocp_protect_fsm_tb_top.sv]
// self-checking bench of the over-current protection controller
`timescale 1ns/1ns
module ocp_protect_fsm_tb_top;
    logic        sys_clk, rst_n, overload, discharge_fet_drive, charge_fet_on, load_test_current_en;
    logic        regulated_supply_out_en, irq, sense_over_threshold, load_above_release;
    logic [1:0]  oc_threshold_sel, s_axi_bresp, s_axi_rresp, rsp;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int          error_cnt = 0;
    int          checked = 0;
    // short delay count keeps both delays within a few dozen cycles
    ocp_protect_fsm #(.DELAY_CYCLES(20)) ocp_protect_fsm_i (.sys_clk, .rst_n, .sense_over_threshold,
        .load_above_release, .discharge_fet_drive, .charge_fet_on, .load_test_current_en, .regulated_supply_out_en,
        .oc_threshold_sel, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    ocp_pack_model ocp_pack_model_i (.overload, .discharge_fet_drive, .load_test_current_en,
        .sense_over_threshold, .load_above_release);
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %0h seen %0h", n, e, g);
        end
    endtask : chk
    // ready is sampled at the falling edge so the handshake edge is known beforehand
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        fork
            begin do @(negedge sys_clk); while (!s_axi_awready); @(posedge sys_clk); s_axi_awvalid <= 1'b0; end
            begin do @(negedge sys_clk); while (!s_axi_wready); @(posedge sys_clk); s_axi_wvalid <= 1'b0; end
        join
        do @(negedge sys_clk); while (!s_axi_bvalid);
        @(posedge sys_clk);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge sys_clk); while (!s_axi_arready);
        @(posedge sys_clk);
        s_axi_arvalid <= 1'b0;
        do @(negedge sys_clk); while (!s_axi_rvalid);
        rdv = s_axi_rdata;
        rsp = s_axi_rresp;
        @(posedge sys_clk);
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic ov(input logic v, input int n);
        @(posedge sys_clk);
        overload <= v;
        repeat (n) @(negedge sys_clk);
    endtask : ov
    task automatic end_of_test;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge sys_clk);
        error_cnt++;
        end_of_test();
    end
    initial begin
        {overload, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        rst_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        chk("fet", 0, discharge_fet_drive);
        chk("supply", 1, regulated_supply_out_en);
        rd(8'hFC);
        chk("resp", ocp_pkg::RESP_SLVERR, rsp);
        wr(ocp_pkg::OFS_CONFIG, 32'h3);
        chk("thr", 3, oc_threshold_sel);
        ov(1'b1, 6);
        ov(1'b0, 6);
        chk("fet", 0, discharge_fet_drive);
        rd(ocp_pkg::OFS_IRQ_STATUS);
        chk("cancel", 32'h4, rdv);
        wr(ocp_pkg::OFS_IRQ_CLEAR, 32'h7);
        wr(ocp_pkg::OFS_IRQ_ENABLE, 32'h1);
        ov(1'b1, 30);
        chk("fet", 1, discharge_fet_drive);
        chk("test", 1, load_test_current_en);
        chk("supply", 1, regulated_supply_out_en);
        chk("irq", 1, irq);
        wr(ocp_pkg::OFS_CTRL, 32'h1);
        chk("chg", 1, charge_fet_on);
        ov(1'b0, 4);
        chk("test", 0, load_test_current_en);
        chk("fet", 1, discharge_fet_drive);
        ov(1'b0, 25);
        chk("fet", 0, discharge_fet_drive);
        chk("chg", 0, charge_fet_on);
        rd(ocp_pkg::OFS_STATUS);
        chk("state", 32'h1, rdv & 32'hF);
        wr(ocp_pkg::OFS_IRQ_CLEAR, 32'h1);
        chk("irq", 0, irq);
        // second protection round: software turns the discharge bit off while protected
        ov(1'b1, 30);
        wr(ocp_pkg::OFS_CTRL, 32'h0);
        chk("fet", 1, discharge_fet_drive);
        ov(1'b0, 30);
        chk("fet", 1, discharge_fet_drive);
        chk("test", 0, load_test_current_en);
        wr(ocp_pkg::OFS_CTRL, 32'h1);
        chk("fet", 0, discharge_fet_drive);
        end_of_test();
    end
endmodule : ocp_protect_fsm_tb_top
